// file: rtl/epw_pkg.sv
// Package for the protected page-write host controller.
// Assumes a 100 MHz system clock and a byte-wide parallel memory outside.
package epw_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 64;
  localparam int CNT_W = 7;
  localparam int IDX_W = 6;
  // ----------------------------------------
  // Unlock command sequence (address, data)
  // ----------------------------------------
  localparam logic [14:0] UNLOCK_ADDR0 = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR1 = 15'h2aaa;
  localparam logic [14:0] UNLOCK_ADDR2 = 15'h5555;
  localparam logic [7:0] UNLOCK_DATA0 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'h55;
  localparam logic [7:0] UNLOCK_DATA2 = 8'ha0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BYTE_LOAD_WINDOW_NS = 150000;
  localparam int PROGRAM_CYCLE_TIME_NS = 10000000;
  localparam int WRITE_PULSE_NS = 200;
  localparam int WRITE_HIGH_NS = 100;
  localparam int ADDR_HOLD_NS = 50;
  localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (WRITE_HIGH_NS + ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = 25;
  localparam int BLC_CYC = BYTE_LOAD_WINDOW_NS / CLK_PERIOD_NS;
  localparam int WC_CYC = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [6:0] {
    EPW_IDLE  = 7'h01,
    EPW_WLOW  = 7'h02,
    EPW_WHIGH = 7'h04,
    EPW_RLOW  = 7'h08,
    EPW_RHIGH = 7'h10,
    EPW_DONE  = 7'h20,
    EPW_FAIL  = 7'h40
  } epw_state_t;
endpackage : epw_pkg

// file: rtl/epw_host.sv
// Host controller writing one protected page into a byte-wide parallel memory.
// Assumes byte data is fed on request; memory pins are driven without buffering.
`timescale 1ns/1ps
module epw_host
  import epw_pkg::*;
#(
  parameter int BLC_CYCLES = BLC_CYC,
  parameter int WC_CYCLES = WC_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Command
  input wire logic start,
  input wire logic [epw_pkg::ADDR_W-1:0] page_addr,
  input wire logic [epw_pkg::CNT_W-1:0] byte_count,
  output logic busy,
  output logic done,
  output logic error,
  // Byte feed
  output logic byte_req,
  output logic [epw_pkg::IDX_W-1:0] byte_idx,
  input wire logic [epw_pkg::DATA_W-1:0] byte_data,
  // Memory pins
  output logic [epw_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic [epw_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_n,
  input wire logic [epw_pkg::DATA_W-1:0] mem_dq_i
);
  import epw_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  epw_state_t st_r, st_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] wc_r;
  logic [CNT_W-1:0] wcnt_r;
  logic [CNT_W-1:0] total_r;
  logic [ADDR_W-1:0] page_r;
  logic [DATA_W-1:0] last_r;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic [DATA_W-1:0] sample_r;
  logic [DATA_W-1:0] rd_r;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [CNT_W-1:0] clamp_cnt = (byte_count == '0) ? CNT_W'(1) :
                               (byte_count > CNT_W'(PAGE_BYTES)) ? CNT_W'(PAGE_BYTES)
                               : byte_count;
  wire in_cmd = wcnt_r < CNT_W'(3);
  wire last_wr = (wcnt_r + CNT_W'(1)) == total_r;
  wire tmr_done = tmr_r == TMR_ZERO;
  // Next write number: pins launched on a state entry must match that write
  wire [CNT_W-1:0] wcnt_nxt = (st_r == EPW_IDLE && start) ? CNT_W'(0) :
                              (st_r == EPW_WHIGH && tmr_done && !last_wr) ?
                              wcnt_r + CNT_W'(1) : wcnt_r;
  wire nxt_cmd = wcnt_nxt < CNT_W'(3);
  wire [IDX_W-1:0] nxt_idx = IDX_W'(wcnt_nxt - CNT_W'(3));
  wire [ADDR_W-1:0] cmd_addr = (wcnt_nxt == CNT_W'(0)) ? UNLOCK_ADDR0 :
                               (wcnt_nxt == CNT_W'(1)) ? UNLOCK_ADDR1 : UNLOCK_ADDR2;
  wire [DATA_W-1:0] cmd_data = (wcnt_nxt == CNT_W'(0)) ? UNLOCK_DATA0 :
                               (wcnt_nxt == CNT_W'(1)) ? UNLOCK_DATA1 : UNLOCK_DATA2;
  // Page bits held from the latched base; only the low six vary
  wire [ADDR_W-1:0] load_addr = {page_r[ADDR_W-1:IDX_W], nxt_idx};
  wire [ADDR_W-1:0] wr_addr = nxt_cmd ? cmd_addr : load_addr;
  wire [DATA_W-1:0] wr_data = nxt_cmd ? cmd_data : byte_data;
  // Bit 6 equal in two successive reads and bit 7 equal to the last loaded byte mean finished
  wire poll_match = (rd_r[7] == last_r[7]) && (rd_r[6] == sample_r[6]);
  wire wc_over = wc_r >= TMR_W'(WC_CYCLES);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      EPW_IDLE:  if (start) st_nxt = EPW_WLOW;
      EPW_WLOW:  if (tmr_done) st_nxt = EPW_WHIGH;
      EPW_WHIGH: if (tmr_done) st_nxt = last_wr ? EPW_RLOW : EPW_WLOW;
      EPW_RLOW:  if (wc_over) st_nxt = EPW_FAIL;
                 else if (tmr_done) st_nxt = EPW_RHIGH;
      EPW_RHIGH: if (wc_over) st_nxt = EPW_FAIL;
                 else if (tmr_done) st_nxt = poll_match ? EPW_DONE : EPW_RLOW;
      EPW_DONE:  st_nxt = EPW_IDLE;
      EPW_FAIL:  st_nxt = EPW_IDLE;
      default:   st_nxt = EPW_IDLE;
    endcase
  end

  wire enter_wlow = (st_nxt == EPW_WLOW) && (st_r != EPW_WLOW);
  wire enter_whigh = (st_nxt == EPW_WHIGH) && (st_r != EPW_WHIGH);
  wire enter_rlow = (st_nxt == EPW_RLOW) && (st_r != EPW_RLOW);
  wire enter_rhigh = (st_nxt == EPW_RHIGH) && (st_r != EPW_RHIGH);
  wire [TMR_W-1:0] tmr_nxt = enter_wlow ? TMR_W'(WP_CYC - 1) :
                             enter_whigh ? TMR_W'(WPH_CYC - 1) :
                             (enter_rlow || enter_rhigh) ? TMR_W'(READ_CYC - 1) :
                             tmr_done ? TMR_ZERO : tmr_r - TMR_W'(1);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= EPW_IDLE;
      tmr_r <= TMR_ZERO;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wcnt_r <= '0;
      total_r <= '0;
      page_r <= '0;
    end else if (st_r == EPW_IDLE && start) begin
      wcnt_r <= '0;
      total_r <= clamp_cnt + CNT_W'(3);
      page_r <= page_addr;
    end else if (st_r == EPW_WHIGH && tmr_done && !last_wr) begin
      wcnt_r <= wcnt_r + CNT_W'(1);
    end
  end

  // Write cycle timer from the first polling read, after the final strobe-high time
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wc_r <= TMR_ZERO;
    end else if (st_r == EPW_WHIGH) begin
      wc_r <= TMR_ZERO;
    end else if ((st_r == EPW_RLOW || st_r == EPW_RHIGH) && !wc_over) begin
      wc_r <= wc_r + TMR_W'(1);
    end
  end

  // Input synchroniser and read sample
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      sample_r <= '0;
      rd_r <= '0;
      last_r <= '0;
    end else begin
      dq_s1_r <= mem_dq_i;
      dq_s2_r <= dq_s1_r;
      // Taken while the read still stands; released lines are not data
      if (st_r == EPW_RLOW && tmr_done) rd_r <= dq_s2_r;
      if (st_r == EPW_RHIGH && tmr_done) sample_r <= rd_r;
      if (st_r == EPW_WLOW && !in_cmd) last_r <= byte_data;
    end
  end

  // ----------------------------------------
  // Pin drive, all registered
  // ----------------------------------------
  wire w_low = st_nxt == EPW_WLOW;
  wire r_low = st_nxt == EPW_RLOW;
  wire w_phase = (st_nxt == EPW_WLOW) || (st_nxt == EPW_WHIGH);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_addr <= '0;
      mem_ce_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_dq_o <= '0;
      mem_dq_oe_n <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      error <= 1'b0;
      byte_req <= 1'b0;
      byte_idx <= '0;
    end else begin
      // Address stays put through strobe high for hold time
      if (enter_wlow) mem_addr <= wr_addr;
      else if (enter_rlow) mem_addr <= {page_r[ADDR_W-1:IDX_W], IDX_W'(total_r - CNT_W'(4))};
      if (enter_wlow) mem_dq_o <= wr_data;
      else if (st_r == EPW_WLOW && !in_cmd) mem_dq_o <= byte_data;
      mem_ce_n <= !(w_low || r_low);
      mem_we_n <= !w_low;
      // Output enable stays high through writes, low only in reads
      mem_oe_n <= !r_low;
      mem_dq_oe_n <= !w_phase;
      busy <= st_nxt != EPW_IDLE;
      done <= st_nxt == EPW_DONE;
      error <= st_nxt == EPW_FAIL;
      byte_req <= w_low && !nxt_cmd;
      byte_idx <= nxt_idx;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  int unsigned gap_cnt;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) gap_cnt <= 0;
    else if (!mem_we_n) gap_cnt <= 0;
    else if (st_r == EPW_WHIGH) gap_cnt <= gap_cnt + 1;
  end
  byte_window_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    gap_cnt < BLC_CYCLES) else $error("byte load window exceeded");
  load_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    total_r <= CNT_W'(PAGE_BYTES + 3)) else $error("too many bytes in cycle");
  relock_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r == EPW_IDLE && start) |=> (wcnt_r == '0)) else $error("unlock not restarted");
  unlock_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(mem_we_n) && wcnt_r == CNT_W'(1) |-> mem_addr == UNLOCK_ADDR1)
    else $error("bad unlock address");
  page_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(mem_we_n) && !in_cmd |-> mem_addr[ADDR_W-1:IDX_W] == page_r[ADDR_W-1:IDX_W])
    else $error("page bits moved");
  oe_guard_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !mem_we_n |-> mem_oe_n && !mem_ce_n) else $error("output enable during write");
  cmd_data_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(mem_we_n) && wcnt_r == CNT_W'(0) |-> mem_dq_o == UNLOCK_DATA0)
    else $error("bad command data");
  poll_bound_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wc_r <= TMR_W'(WC_CYCLES)) else $error("polling overran write cycle");
  page_done_c: cover property (@(posedge clk_sys) disable iff (!nrst) done);
  page_fail_c: cover property (@(posedge clk_sys) disable iff (!nrst) error);
  poll_loop_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    (st_r == EPW_RHIGH) ##1 (st_r == EPW_RLOW));
endmodule : epw_host

// file: sim/epw_mem_model.sv
// Behavioural byte-wide memory: write guard, page latch, polling reads.
// Assumes the host clock as its time base.
`timescale 1ns/1ps
module epw_mem_model
  import epw_pkg::*;
#(parameter int BLC = 200, parameter int PROG = 300) (
  // Clock, reset, test knob
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slow,
  // Memory pins
  input wire logic [epw_pkg::ADDR_W-1:0] a,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [epw_pkg::DATA_W-1:0] d,
  input wire logic d_oe_n,
  output logic [epw_pkg::DATA_W-1:0] q,
  output logic viol
);
  logic [7:0] mem [32768];
  logic [7:0] pb [64];
  logic [63:0] pv;
  logic [8:0] pg;
  logic [7:0] ld;
  logic [1:0] st;
  logic lo, wq, rq, tg;
  int lt, bt;
  wire wr = !ce_n && !we_n;
  wire rd = !ce_n && !oe_n && we_n;
  wire bsy = (bt != 0) || lo;
  // Undriven data lines read back inverted, never a stale copy
  wire [7:0] din = d_oe_n ? ~d : d;
  wire [14:0] ua = (st == 2'd1) ? UNLOCK_ADDR1 : (st == 2'd2) ? UNLOCK_ADDR2 : UNLOCK_ADDR0;
  wire [7:0] ud = (st == 2'd1) ? UNLOCK_DATA1 : (st == 2'd2) ? UNLOCK_DATA2 : UNLOCK_DATA0;
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {st, lo, wq, rq, tg, viol, pv} <= '0;
      lt <= 0;
      bt <= 0;
      q <= 8'h00;
    end else begin
      wq <= wr;
      rq <= rd;
      if (bt != 0) bt <= bt - 1;
      if ((wr && !oe_n) || (rd && !d_oe_n)) viol <= 1'b1;
      if (lo && !wr) lt <= lt + 1;
      if (!wr && wq && bt == 0) begin
        lt <= 0;
        if (lo) begin
          if (pv != 0 && a[14:6] != pg) viol <= 1'b1;
          pg <= a[14:6];
          pb[a[5:0]] <= din;
          pv[a[5:0]] <= 1'b1;
          ld <= din;
        end else if (a == ua && din == ud) begin
          st <= st + 2'd1;
          lo <= (st == 2'd2);
        end else begin
          st <= 2'd0;
          bt <= PROG;
        end
      end
      if (lo && lt == BLC) begin
        for (int i = 0; i < 64; i++) if (pv[i]) mem[{pg, i[5:0]}] <= pb[i];
        {lo, st, pv} <= '0;
        lt <= 0;
        bt <= slow ? 10 * PROG : PROG;
      end
      if (rd && !rq) begin
        q <= bsy ? {~ld[7], tg, ld[5:0]} : mem[a];
        tg <= tg ^ bsy;
      end else if (!rd && rq) q <= ~q;
    end
  end
endmodule : epw_mem_model

// file: sim/eeprom_protected_page_write_tb.sv
// Self-checking bench for the protected page-write host.
// Assumes the behavioural memory model on the far side.
`timescale 1ns/1ps
module eeprom_protected_page_write_tb;
  import epw_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic [14:0] page_addr = 15'h0000;
  logic [6:0] byte_count = 7'h00;
  logic [7:0] byte_data = 8'h00;
  logic busy, done, error, byte_req, ce_n, we_n, oe_n, dq_oe_n, viol;
  logic [5:0] byte_idx;
  logic [14:0] addr;
  logic [7:0] dq_o, dq_i;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int nreq = 0;
  logic req_q = 1'b0;
  always @(posedge clk_sys) begin
    req_q <= byte_req;
    if (byte_req && !req_q) nreq <= nreq + 1;
  end
  epw_host #(.BLC_CYCLES(200), .WC_CYCLES(2000)) epw_host_i (.clk_sys(clk_sys),
    .nrst(nrst), .start(start), .page_addr(page_addr), .byte_count(byte_count),
    .busy(busy), .done(done), .error(error), .byte_req(byte_req), .byte_idx(byte_idx),
    .byte_data(byte_data), .mem_addr(addr), .mem_ce_n(ce_n), .mem_we_n(we_n),
    .mem_oe_n(oe_n), .mem_dq_o(dq_o), .mem_dq_oe_n(dq_oe_n), .mem_dq_i(dq_i));
  epw_mem_model #(.BLC(200), .PROG(300)) epw_mem_model_i (.clk_sys(clk_sys), .nrst(nrst),
    .slow(slow), .a(addr), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .d(dq_o),
    .d_oe_n(dq_oe_n), .q(dq_i), .viol(viol));
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) byte_data <= {2'b00, byte_idx} ^ 8'h3c;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk
  task automatic run(input logic [14:0] pa, input logic [6:0] cnt, input logic ign);
    @(negedge clk_sys);
    page_addr = pa;
    byte_count = cnt;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    // Second start while busy must be dropped, page moved to catch a relatch
    if (ign) begin
      repeat (100) @(negedge clk_sys);
      page_addr = 15'h7fff;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
    end
    for (int i = 0; i < 9000 && done !== 1'b1 && error !== 1'b1; i++) @(negedge clk_sys);
  endtask : run
  task automatic t_page(input string nm, input logic [14:0] pa, input logic [6:0] cnt,
                        input int n);
    int base;
    base = nreq;
    run(pa, cnt, cnt == 7'd64);
    chk("done", 8'h01, {7'h00, done});
    chk("byte reqs", n[7:0], 8'(nreq - base));
    for (int i = 0; i <= n && i < 64; i++)
      chk("byte", (i < n) ? (i[7:0] ^ 8'h3c) : 8'hff, epw_mem_model_i.mem[{pa[14:6], i[5:0]}]);
    chk("next page", 8'hff, epw_mem_model_i.mem[{pa[14:6] + 9'd1, 6'd0}]);
    chk("cmd 5555", 8'hff, epw_mem_model_i.mem[UNLOCK_ADDR0]);
    chk("cmd 2aaa", 8'hff, epw_mem_model_i.mem[UNLOCK_ADDR1]);
    chk("relocked", 8'h00, {5'h00, epw_mem_model_i.lo, epw_mem_model_i.st});
    chk("pin misuse", 8'h00, {7'h00, viol});
    @(negedge clk_sys);
    chk("idle", 8'h00, {6'h00, busy, done});
    $display("test %s done", nm);
  endtask : t_page
  task automatic t_slow;
    slow = 1'b1;
    run(15'h0c00, 7'd2, 1'b0);
    chk("error", 8'h01, {7'h00, error});
    chk("no done", 8'h00, {7'h00, done});
    slow = 1'b0;
    $display("test slow done");
  endtask : t_slow
  initial begin
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    t_page("full", 15'h1240, 7'd64, 64);
    t_page("single", 15'h0080, 7'd0, 1);
    t_page("clamp", 15'h0400, 7'd100, 64);
    t_slow();
    report_and_stop();
  end
endmodule : eeprom_protected_page_write_tb
